// File: verilog/gsh_spi_host.sv
// host-side master for the generic serial register and frame port
// assumes user logic on clk drives requests and write words; device output is asynchronous
//
// Functional notes
// R1: device picks generic or alternative protocol from its configuration pins.
// R2: registers are 32-bit words; every access moves whole words.
// R3: single-word and multi-word burst accesses are both supported.
// R4: all header fields and data go most significant bit first.
// R5: header is 1, 0, direction bit, then 13-bit address top bit first.
// R6: reads send a turnaround byte then zeros; data returns after it.
// R7: writes without check byte send data right after the address.
// R8: frame bursts are whole 4-byte words; last word holds 1 to 4 bytes.
// R9: length register holds frame length plus header; padding bytes ignored.
// R10: device enables check bytes only by a configuration pin at power-up; the host here samples crc_enable at every request.
// R11: check byte is 8-bit, polynomial x^8+x^2+x+1, seed zero.
// R12: with check enabled a check byte follows the address, before turnaround.
// R13: register transactions add a check byte after every data word.
// R14: frame transactions carry no per-word check bytes.
// R15: half duplex: one transaction either writes or reads, never both.
// R16: host runs the serial clock at 25 MHz.
// R17: every frame through the fifo ports starts with a 2-byte header.
// R18: latch-low read-only bits hold a low until read.
// R19: latch-high read-only bits hold a high until read.
// R20: self-clearing bits return to zero after their action.
// R21: write-one-to-clear bits clear on 1, keep on 0.
// R22: device discards a register write whose check byte mismatches.
// R23: chip select low frames each transaction; release restarts the bit count.
// R24: each check byte covers the field since the previous one, seed zero.
`timescale 1ns/10ps
module gsh_spi_host
    import gsh_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire logic              crc_enable,
    input  wire logic              req_valid,
    input  wire gsh_req_s          req,
    output logic                   req_ready,
    input  wire logic              wr_valid,
    input  wire logic [WORD_W-1:0] wr_data,
    output logic                   wr_ready,
    output logic                   rd_valid,
    output logic      [WORD_W-1:0] rd_data,
    output logic                   rd_crc_err,
    output logic                   done,
    output logic                   done_err,
    output gsh_pins_s              pins,
    input  wire logic              miso
);

    typedef struct packed {
        gsh_state_e        st;
        gsh_req_s          req;
        logic              crc_on;
        logic [1:0]        tick;
        logic [5:0]        bitcnt;
        logic [CNT_W-1:0]  wordcnt;
        logic [WORD_W-1:0] tx_sr;
        logic [WORD_W-1:0] rx_sr;
        logic [CRC_W-1:0]  tx_crc;
        logic [CRC_W-1:0]  rx_crc;
        logic              miso_m;
        logic              miso_s;
        gsh_pins_s         pins;
        logic              req_ready;
        logic              wr_ready;
        logic              rd_valid;
        logic [WORD_W-1:0] rd_data;
        logic              rd_err;
        logic              done;
        logic              err;
    } gsh_regs_s;

    gsh_regs_s        q;
    gsh_regs_s        d;
    logic [CRC_W-1:0] tx_crc_nxt;
    logic [CRC_W-1:0] rx_crc_nxt;

    gsh_crc8 u_tx_crc (
        .crc_in  (q.tx_crc),
        .bit_in  (q.pins.mosi),
        .crc_out (tx_crc_nxt)
    );

    gsh_crc8 u_rx_crc (
        .crc_in  (q.rx_crc),
        .bit_in  (q.miso_s),
        .crc_out (rx_crc_nxt)
    );

    always_comb
    begin
        logic bit_end;
        logic half_end;
        logic next_word;
        bit_end   = 1'b0;
        half_end  = 1'b0;
        next_word = 1'b0;
        d          = q;
        d.miso_m   = miso;
        d.miso_s   = q.miso_m;
        d.rd_valid = 1'b0;
        d.done     = 1'b0;

        // serial clock from a divider, low when idle
        if (q.st != GSH_IDLE && q.st != GSH_LOADW)
        begin
            if (q.tick == TICK_LAST) // R16
            begin
                d.tick   = 2'h0;
                half_end = 1'b1;
            end
            else
            begin
                d.tick = q.tick + 2'h1;
            end
        end
        if (half_end && q.st != GSH_FINISH)
        begin
            d.pins.sclk = ~q.pins.sclk;
            bit_end     = q.pins.sclk;
        end

        // shift on the falling edge; device output is read from the synchroniser
        if (bit_end)
        begin
            d.tx_sr  = {q.tx_sr[WORD_W-2:0], 1'b0}; // R4
            d.rx_sr  = {q.rx_sr[WORD_W-2:0], q.miso_s};
            d.bitcnt = q.bitcnt - 6'h1;
        end

        case (q.st)
            GSH_IDLE:
            begin
                d.pins.sclk = 1'b0;
                d.pins.cs_n = 1'b1;
                if (req_valid && q.req_ready)
                begin
                    d.req       = req;
                    d.crc_on    = crc_enable; // R10
                    d.req_ready = 1'b0;
                    d.wordcnt   = (req.words == 8'h00) ? 8'h01 : req.words; // R2 R3
                    d.tx_sr     = {HDR_START, req.write, req.addr, 16'h0000}; // R5
                    d.tx_crc    = CRC_SEED; // R24
                    d.bitcnt    = HDR_LAST_BIT;
                    d.tick      = 2'h0;
                    d.err       = 1'b0;
                    d.pins.cs_n = 1'b0; // R23
                    d.st        = GSH_HDR;
                end
            end
            GSH_HDR:
            begin
                if (bit_end)
                begin
                    d.tx_crc = tx_crc_nxt;
                    if (q.bitcnt == 6'h0)
                    begin
                        d.bitcnt = BYTE_LAST_BIT;
                        if (q.crc_on)
                        begin
                            d.tx_sr = {tx_crc_nxt, 24'h000000}; // R12
                            d.st    = GSH_HCRC;
                        end
                        else if (q.req.write == DIR_READ)
                        begin
                            d.tx_sr = '0;
                            d.st    = GSH_TURN;
                        end
                        else
                        begin
                            d.wr_ready = 1'b1; // R7
                            d.st       = GSH_LOADW;
                        end
                    end
                end
            end
            GSH_HCRC:
            begin
                if (bit_end && q.bitcnt == 6'h0)
                begin
                    d.tx_sr  = '0;
                    d.bitcnt = BYTE_LAST_BIT;
                    if (q.req.write == DIR_READ)
                    begin
                        d.st = GSH_TURN; // R12
                    end
                    else
                    begin
                        d.wr_ready = 1'b1;
                        d.st       = GSH_LOADW;
                    end
                end
            end
            GSH_TURN:
            begin
                if (bit_end && q.bitcnt == 6'h0)
                begin
                    d.tx_sr  = '0; // R6
                    d.rx_crc = CRC_SEED;
                    d.bitcnt = WORD_LAST_BIT;
                    d.st     = GSH_DATA;
                end
            end
            GSH_LOADW:
            begin
                d.pins.sclk = 1'b0;
                if (wr_valid && q.wr_ready)
                begin
                    d.wr_ready = 1'b0;
                    d.tx_sr    = wr_data; // R7
                    d.tx_crc   = CRC_SEED; // R24
                    d.bitcnt   = WORD_LAST_BIT;
                    d.tick     = 2'h0;
                    d.st       = GSH_DATA;
                end
            end
            GSH_DATA:
            begin
                if (bit_end)
                begin
                    if (q.req.write == DIR_WRITE)
                    begin
                        d.tx_crc = tx_crc_nxt;
                    end
                    else
                    begin
                        d.rx_crc = rx_crc_nxt;
                    end
                    if (q.bitcnt == 6'h0)
                    begin
                        d.rd_data = {q.rx_sr[WORD_W-2:0], q.miso_s};
                        if (q.crc_on && !q.req.frame) // R13 R14
                        begin
                            d.bitcnt = BYTE_LAST_BIT;
                            d.tx_sr  = (q.req.write == DIR_WRITE) ?
                                       {tx_crc_nxt, 24'h000000} : '0;
                            d.st     = GSH_DCRC;
                        end
                        else
                        begin
                            d.rd_valid = (q.req.write == DIR_READ); // R15
                            d.rd_err   = 1'b0;
                            next_word  = 1'b1;
                        end
                    end
                end
            end
            GSH_DCRC:
            begin
                if (bit_end && q.bitcnt == 6'h0)
                begin
                    if (q.req.write == DIR_READ)
                    begin
                        d.rd_valid = 1'b1;
                        d.rd_err   = ({q.rx_sr[6:0], q.miso_s} != q.rx_crc); // R13 R24
                        d.err      = q.err | d.rd_err;
                    end
                    next_word = 1'b1;
                end
            end
            GSH_FINISH:
            begin
                d.pins.sclk = 1'b0;
                if (half_end)
                begin
                    if (q.bitcnt != 6'h0)
                    begin
                        d.pins.cs_n = 1'b1; // R23
                        d.bitcnt    = 6'h0;
                    end
                    else
                    begin
                        d.done      = 1'b1;
                        d.req_ready = 1'b1;
                        d.st        = GSH_IDLE;
                    end
                end
            end
            default:
            begin
                d.st = GSH_IDLE;
            end
        endcase

        // whole words only; padding of a frame's last word is the caller's data
        if (next_word)
        begin
            if (q.wordcnt == 8'h01) // R8 R9 R17
            begin
                d.tx_sr  = '0;
                d.bitcnt = 6'h1;
                d.tick   = 2'h0;
                d.st     = GSH_FINISH;
            end
            else
            begin
                d.wordcnt = q.wordcnt - 8'h01; // R3
                d.bitcnt  = WORD_LAST_BIT;
                d.rx_crc  = CRC_SEED;
                if (q.req.write == DIR_WRITE)
                begin
                    d.wr_ready = 1'b1;
                    d.st       = GSH_LOADW;
                end
                else
                begin
                    d.tx_sr = '0;
                    d.st    = GSH_DATA;
                end
            end
        end

        d.pins.mosi = d.tx_sr[WORD_W-1];
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            q           <= '0;
            q.st        <= GSH_IDLE;
            q.pins.cs_n <= 1'b1;
            q.req_ready <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    assign req_ready  = q.req_ready;
    assign wr_ready   = q.wr_ready;
    assign rd_valid   = q.rd_valid;
    assign rd_data    = q.rd_data;
    assign rd_crc_err = q.rd_err;
    assign done       = q.done;
    assign done_err   = q.err;
    assign pins       = q.pins;

endmodule : gsh_spi_host

// File: pkg/gsh_pkg.sv
// constants, state codes and carriers of the generic serial host controller
// assumes one 200 MHz clock; the serial clock is divided from it
package gsh_pkg;

    localparam int unsigned CLK_HZ        = 200_000_000;
    localparam int unsigned SCLK_HZ       = 25_000_000;
    localparam int unsigned SCLK_HALF_CYC = CLK_HZ / (2 * SCLK_HZ);
    localparam logic [1:0]  TICK_LAST     = 2'(SCLK_HALF_CYC - 1);

    localparam int unsigned ADDR_W        = 13;
    localparam int unsigned WORD_W        = 32;
    localparam int unsigned CRC_W         = 8;
    localparam int unsigned CNT_W         = 8;
    localparam logic [7:0]  CRC_POLY      = 8'h07;
    localparam logic [7:0]  CRC_SEED      = 8'h00;
    localparam logic        DIR_READ      = 1'b0;
    localparam logic        DIR_WRITE     = 1'b1;
    localparam logic [1:0]  HDR_START     = 2'h2;
    localparam logic [5:0]  HDR_LAST_BIT  = 6'h0F;
    localparam logic [5:0]  BYTE_LAST_BIT = 6'h07;
    localparam logic [5:0]  WORD_LAST_BIT = 6'h1F;

    typedef enum logic [2:0] {
        GSH_IDLE   = 3'h0,
        GSH_HDR    = 3'h1,
        GSH_HCRC   = 3'h2,
        GSH_TURN   = 3'h3,
        GSH_LOADW  = 3'h4,
        GSH_DATA   = 3'h5,
        GSH_DCRC   = 3'h6,
        GSH_FINISH = 3'h7
    } gsh_state_e;

    typedef struct packed {
        logic              write;
        logic              frame;
        logic [ADDR_W-1:0] addr;
        logic [CNT_W-1:0]  words;
    } gsh_req_s;

    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic mosi;
    } gsh_pins_s;

endpackage : gsh_pkg

// File: verilog/gsh_crc8.sv
// one serial step of the 8-bit protocol check value
// assumes the caller holds the running value and feeds one bit per step
`timescale 1ns/10ps
module gsh_crc8
    import gsh_pkg::*;
(
    input  wire logic [CRC_W-1:0] crc_in,
    input  wire logic             bit_in,
    output logic      [CRC_W-1:0] crc_out
);

    logic fb;

    always_comb
    begin
        fb      = crc_in[CRC_W-1] ^ bit_in;
        crc_out = {crc_in[CRC_W-2:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00); // R11
    end

endmodule : gsh_crc8

// File: dv/gsh_dev_model.sv
// device model of the generic serial port: records host bits, answers reads
// assumes mode 0 pins from the host; the fifo address is a free choice
`timescale 1ns/10ps
module gsh_dev_model
    import gsh_pkg::*;
#(
    parameter logic [12:0] FIFO_ADDR = 13'h0031
)
(
    input  wire logic sclk,
    input  wire logic cs_n,
    input  wire logic mosi,
    input  wire logic crc_on,
    input  wire logic bad_crc,
    output logic      miso
);
    logic [255:0] rx;
    int           n;
    logic [15:0]  h;
    logic [39:0]  wv;
    int           s;
    int           k;
    int           l;

    function automatic logic [7:0] crc8(input logic [31:0] d, input int nb);
        logic [7:0] c;
        c = 8'h00;
        for (int i = nb - 1; i >= 0; i--)
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
        return c;
    endfunction : crc8

    function automatic logic [31:0] word(input int i);
        // register contents are fixed: latch, self-clear and clear-on-one bits never move
        return 32'hC35A_0F00 + 32'(i);
    endfunction : word

    initial
    begin
        miso = 1'b0;
        n    = 0;
        rx   = '0;
    end

    always @(negedge cs_n)
    begin
        n  = 0;
        rx = '0;
    end

    always @(posedge sclk)
    begin
        if (!cs_n)
        begin
            rx = {rx[254:0], mosi};
            n  = n + 1;
        end
    end

    // only the generic protocol is modelled, check bytes follow the strap input
    always @(negedge sclk or posedge cs_n)
    begin
        h  = 16'(rx >> (n - 16));
        s  = crc_on ? 32 : 24;
        l  = (crc_on && h[12:0] != FIFO_ADDR) ? 40 : 32;
        k  = n - s;
        wv = {word(k / l), crc8(word(k / l), 32) ^ {8{bad_crc}}};
        if (!cs_n && n >= s && h[15:13] == 3'b100)
            miso <= wv[39 - k % l];
        else
            miso <= ~miso;
    end
endmodule : gsh_dev_model

// File: dv/gsh_spi_host_sva.sv
// assertions on the host controller's ports
// assumes one clock domain with synchronous active-high reset
`timescale 1ns/10ps
module gsh_spi_host_sva
    import gsh_pkg::*;
(
    input wire logic      clk,
    input wire logic      srst,
    input wire logic      req_valid,
    input wire logic      req_ready,
    input wire logic      wr_ready,
    input wire logic      rd_valid,
    input wire logic      done,
    input wire gsh_pins_s pins
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    chk_take_cs: assert property (req_valid && req_ready |=> !pins.cs_n)
        else $error("chip select not low after request");
    chk_idle_sclk: assert property (pins.cs_n |-> !pins.sclk)
        else $error("serial clock outside frame");
    chk_high_half: assert property ($rose(pins.sclk) |-> pins.sclk [*4] ##1 !pins.sclk)
        else $error("serial clock high time wrong");
    chk_low_half: assert property ($fell(pins.sclk) |-> !pins.sclk [*4])
        else $error("serial clock low time short");
    chk_first_bits: assert property ($fell(pins.cs_n) |->
        pins.mosi ##8 $fell(pins.sclk) ##2 !pins.mosi)
        else $error("header start bits wrong");
    chk_mosi_hold: assert property (pins.sclk |-> $stable(pins.mosi))
        else $error("data line moved while clock high");
    chk_rd_inside: assert property (rd_valid |-> !pins.cs_n)
        else $error("read word outside frame");
    chk_done_gap: assert property ($rose(pins.cs_n) |-> !done [*4] ##1 done)
        else $error("done not four cycles after release");
    chk_ready_idle: assert property (req_ready |-> pins.cs_n)
        else $error("ready while frame open");
    chk_stall_low: assert property (wr_ready |-> !pins.sclk)
        else $error("clock runs while waiting for word");

    cover property (rd_valid);
    cover property (wr_ready);
    cover property (done);
endmodule : gsh_spi_host_sva

// File: dv/gsh_spi_host_test.sv
// self-checking bench for the host controller against the device model
// assumes the model answers reads and records every host bit
`timescale 1ns/10ps
module gsh_spi_host_test
    import gsh_pkg::*;
;
    logic clk, srst, crc_on, bad, req_valid, req_ready, wr_valid, wr_ready;
    logic rd_valid, rd_crc_err, done, done_err, miso;
    logic [31:0] wr_data, rd_data;
    gsh_req_s    req;
    gsh_pins_s   pins;
    logic [255:0] e;
    int ne, bad_count, checked;

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    gsh_spi_host uut (.clk(clk), .srst(srst), .crc_enable(crc_on), .req_valid(req_valid),
        .req(req), .req_ready(req_ready), .wr_valid(wr_valid), .wr_data(wr_data),
        .wr_ready(wr_ready), .rd_valid(rd_valid), .rd_data(rd_data), .rd_crc_err(rd_crc_err),
        .done(done), .done_err(done_err), .pins(pins), .miso(miso));
    gsh_dev_model dev (.sclk(pins.sclk), .cs_n(pins.cs_n), .mosi(pins.mosi),
        .crc_on(crc_on), .bad_crc(bad), .miso(miso));

    task automatic results;
        if (bad_count == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : results

    task automatic check(input logic [255:0] seen, input logic [255:0] want);
        checked++;
        if (seen !== want)
        begin
            bad_count++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, want);
        end
    endtask : check

    task automatic put(input logic [31:0] v, input int nb);
        e  = (e << nb) | 256'(v);
        ne = ne + nb;
    endtask : put

    // one transaction; expected wire bits built alongside
    task automatic xfer(input logic w, input logic f, input logic [12:0] a, input int nw);
        int k;
        int r;
        logic [31:0] d;
        e  = '0;
        ne = 0;
        k  = 0;
        r  = 0;
        put({16'h0, 2'b10, w, a}, 16);
        if (crc_on)
            put(32'(dev.crc8({16'h0, 2'b10, w, a}, 16)), 8);
        if (!w)
            put(32'h0, 8);
        for (int i = 0; i < nw; i++)
        begin
            d = w ? (32'h5A3C_9600 | 32'(i)) : 32'h0;
            put(d, 32);
            if (crc_on && !f)
                put(w ? 32'(dev.crc8(d, 32)) : 32'h0, 8);
        end
        @(negedge clk);
        req_valid = 1'b1;
        req = '{w, f, a, 8'(nw)};
        while (!req_ready)
            @(negedge clk);
        @(negedge clk);
        req_valid = 1'b0;
        for (int t = 0; t < 9000 && done !== 1'b1; t++)
        begin
            if (rd_valid === 1'b1)
            begin
                check(rd_data, dev.word(r));
                check(rd_crc_err, bad && crc_on && !f);
                r++;
            end
            if (wr_ready === 1'b1 && !wr_valid)
            begin
                wr_data  = 32'h5A3C_9600 | 32'(k);
                wr_valid = 1'b1;
                k++;
            end
            else
                wr_valid = 1'b0;
            @(negedge clk);
        end
        check(done, 1'b1);
        check(done_err, bad && crc_on && !f && !w);
        check(r, w ? 0 : nw);
        check(dev.n, ne);
        check(dev.rx, e);
    endtask : xfer

    task automatic t_wr_single;
        crc_on = 1'b0;
        xfer(1'b1, 1'b0, 13'h1ABC, 1);
    endtask : t_wr_single

    task automatic t_wr_ctrl_crc;
        crc_on = 1'b1;
        xfer(1'b1, 1'b0, 13'h0155, 3);
    endtask : t_wr_ctrl_crc

    task automatic t_wr_frame_crc;
        xfer(1'b1, 1'b1, dev.FIFO_ADDR, 3);
    endtask : t_wr_frame_crc

    task automatic t_rd_ctrl_crc;
        xfer(1'b0, 1'b0, 13'h1ABC, 2);
    endtask : t_rd_ctrl_crc

    task automatic t_rd_bad_crc;
        bad = 1'b1;
        xfer(1'b0, 1'b0, 13'h0155, 2);
        bad = 1'b0;
    endtask : t_rd_bad_crc

    task automatic t_rd_frame;
        crc_on = 1'b0;
        xfer(1'b0, 1'b1, dev.FIFO_ADDR, 3);
    endtask : t_rd_frame

    task automatic t_reset_mid;
        @(negedge clk);
        req_valid = 1'b1;
        req = '{1'b0, 1'b0, 13'h0155, 8'h02};
        @(negedge clk);
        req_valid = 1'b0;
        repeat (60) @(negedge clk);
        check(pins.cs_n, 1'b0);
        srst = 1'b1;
        repeat (2) @(negedge clk);
        check(pins, 3'b010);
        check(req_ready, 1'b1);
        srst = 1'b0;
    endtask : t_reset_mid

    initial
    begin
        {srst, crc_on, bad, req_valid, wr_valid} = 5'h10;
        req     = '0;
        wr_data = '0;
        repeat (20) @(negedge clk);
        srst = 1'b0;
        t_wr_single;
        t_wr_ctrl_crc;
        t_wr_frame_crc;
        t_rd_ctrl_crc;
        t_rd_bad_crc;
        t_rd_frame;
        t_reset_mid;
        t_wr_single;
        results;
    end

    initial
    begin
        #300000;
        bad_count++;
        results;
    end
endmodule : gsh_spi_host_test

bind gsh_spi_host gsh_spi_host_sva chk (.clk(clk), .srst(srst), .req_valid(req_valid),
    .req_ready(req_ready), .wr_ready(wr_ready), .rd_valid(rd_valid), .done(done),
    .pins(pins));
